// >>> src/cnt_preset_pkg.sv
// Package: types and constants for the counter preset and match channel
package cnt_preset_pkg;

   localparam int unsigned CNT_W = 32;

   // Compare points per channel and their positions
   localparam int unsigned NUM_POINTS = 2;
   localparam int unsigned POINT_ONE  = 0;
   localparam int unsigned POINT_TWO  = 1;

   typedef logic signed [CNT_W-1:0] count_t;

   // Index-input preset trigger selection
   typedef enum logic [1:0]
   {
      TRIG_RISE,
      TRIG_FALL,
      TRIG_BOTH,
      TRIG_LEVEL
   } index_trig_t;

   localparam count_t COUNT_RST   = 32'sh0000_0000;
   localparam count_t PRESET_RST  = 32'sh0000_0000;
   localparam count_t COMPARE_RST = 32'sh0000_0000;
   localparam count_t COUNT_STEP  = 32'sh0000_0001;

   // Configuration of the preset sources
   typedef struct packed
   {
      index_trig_t trig_sel;
      logic        req_flag_en;
   } preset_cfg_t;

   // Comparison result of one compare point against the count
   typedef struct packed
   {
      logic lt;
      logic eq;
      logic gt;
   } cmp_res_t;

   // Host write port: strobe with data
   typedef struct packed
   {
      logic   wr;
      count_t data;
   } wr_port_t;

endpackage : cnt_preset_pkg

// >>> src/cnt_compare.sv
// Signed comparator of the current count against one compare point
module cnt_compare
   import cnt_preset_pkg::*;
(
   input  wire count_t   i_count,
   input  wire count_t   i_point,
   output cmp_res_t      o_res
);

   // signed compare
   // Both operands are signed typed, so the relations are signed
   assign o_res.lt = (i_count <  i_point);
   assign o_res.eq = (i_count == i_point);
   assign o_res.gt = (i_count >  i_point);

endmodule // cnt_compare

// >>> src/cnt_match_point.sv
// Counter channel: preset sources, request flag, compare points, match pins
//
// Summary of operation
// - Any preset event loads the held preset value; counting resumes from it
// - Index preset trigger: rising, falling, both edges, or level while high
// - Option lets index presets set the request flag; ignored in level mode
// - While the request flag is set, every preset source is ignored
// - Request flag clears on the clear command; program must clear to re-arm
// - Preset value write stores the value without touching the count
// - Index and program presets load regardless of the count enable command
// - Program preset loads the count on the rising edge of its command
// - Two independent writable compare points, each with its own match flag
// - Less-than flag on while count below point one, off otherwise
// - Greater-than flag on while count exceeds point one
// - Count equal to point one sets match flag and drives match pin
// - Match pins driven only while the single output enable is on
// - Match reset command clears and holds off flag and pin
// - Releasing match reset during equality turns flag and pin on again
// - Match flag latches; a new match needs a match reset first
// - Match flag sets on equality whatever the output enable state
// - Count is a signed 32-bit linear value; comparisons are signed
module cnt_match_point
(
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_rst_n,
   input  wire cnt_preset_pkg::preset_cfg_t i_preset_cfg,
   input  wire logic                        i_index,
   input  wire logic                        i_step_up,
   input  wire logic                        i_step_dn,
   input  wire logic                        i_count_enable_cmd,
   input  wire logic                        i_program_preset_cmd,
   input  wire cnt_preset_pkg::wr_port_t    i_preset_value_write_op,
   input  wire cnt_preset_pkg::wr_port_t    i_compare_point_write_op_one,
   input  wire cnt_preset_pkg::wr_port_t    i_compare_point_write_op_two,
   input  wire logic                        i_match_reset_cmd_one,
   input  wire logic                        i_match_reset_cmd_two,
   input  wire logic                        i_match_output_enable_cmd,
   input  wire logic                        i_ext_preset_request_clear_cmd,
   output cnt_preset_pkg::count_t           o_current_count,
   output logic                             o_ext_preset_request_flag,
   output cnt_preset_pkg::cmp_res_t         o_res_one,
   output logic                             o_match_flag_one,
   output logic                             o_match_flag_two,
   output logic                             o_match_out_one,
   output logic                             o_match_out_two
);

   import cnt_preset_pkg::*;

   // ==========================================================================
   // Declarations
   // ==========================================================================

   // Count and preset value
   count_t                  count_q;
   count_t                  preset_q;

   // Index pin synchroniser and edge history
   logic                    idx_s1_q;
   logic                    idx_s2_q;
   logic                    idx_s3_q;
   logic                    idx_rise;
   logic                    idx_fall;
   logic                    index_fire;

   // Program preset command history
   logic                    prog_prev_q;
   logic                    prog_rise;

   // Preset decision and request flag
   logic                    preset_fire;
   logic                    req_q;
   logic                    req_set;

   // Count steps, gated by the count enable
   logic                    move_up;
   logic                    move_dn;

   // Compare points, comparator results and match state
   count_t                  point_q [NUM_POINTS];
   wr_port_t                point_wr [NUM_POINTS];
   cmp_res_t                res [NUM_POINTS];
   cmp_res_t                res_one_q;
   logic [NUM_POINTS-1:0]   mrst;
   logic [NUM_POINTS-1:0]   flag_d;
   logic [NUM_POINTS-1:0]   flag_q;
   logic [NUM_POINTS-1:0]   out_q;

   // ==========================================================================
   // Decoding helpers
   // ==========================================================================

   function automatic logic index_hit
   (
      input index_trig_t sel,
      input logic        rise,
      input logic        fall,
      input logic        level
   );
      logic hit;
      hit = 1'b0;
      case (sel)
         TRIG_RISE:  hit = rise;
         TRIG_FALL:  hit = fall;
         TRIG_BOTH:  hit = rise | fall;
         TRIG_LEVEL: hit = level;
         default:    hit = 1'b0;
      endcase
      return hit;
   endfunction

   // edge modes only
   // Level mode reloads every cycle, so it never sets the request flag
   function automatic logic is_edge_mode
   (
      input index_trig_t sel
   );
      return (sel != TRIG_LEVEL);
   endfunction

   // ==========================================================================
   // Index pin synchroniser
   // ==========================================================================

   // The pin is asynchronous; only the second and third stages are decoded.
   // History resets low, the idle level of the pin, so reset gives no edge.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         idx_s1_q <= 1'b0;
         idx_s2_q <= 1'b0;
         idx_s3_q <= 1'b0;
      end
      else
      begin
         idx_s1_q <= i_index;
         idx_s2_q <= idx_s1_q;
         idx_s3_q <= idx_s2_q;
      end
   end

   assign idx_rise   = idx_s2_q & ~idx_s3_q;
   assign idx_fall   = ~idx_s2_q & idx_s3_q;
   assign index_fire = index_hit(i_preset_cfg.trig_sel, idx_rise, idx_fall,
                                 idx_s2_q);

   // ==========================================================================
   // Program preset command
   // ==========================================================================

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         prog_prev_q <= 1'b0;
      else
         prog_prev_q <= i_program_preset_cmd;
   end

   assign prog_rise = i_program_preset_cmd & ~prog_prev_q;

   // ==========================================================================
   // Preset decision and request flag
   // ==========================================================================

   assign preset_fire = ~req_q & (index_fire | prog_rise);

   assign req_set = ~req_q & index_fire & i_preset_cfg.req_flag_en &
                    is_edge_mode(i_preset_cfg.trig_sel);

   // flag clear
   // A new index event is only honoured while the flag is clear, so the
   // set can never meet a clear of an already set flag.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         req_q <= 1'b0;
      else if (req_set)
         req_q <= 1'b1;
      else if (i_ext_preset_request_clear_cmd)
         req_q <= 1'b0;
   end

   // ==========================================================================
   // Preset value register
   // ==========================================================================

   // preset write
   // An index preload in the same cycle still takes the old value
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         preset_q <= PRESET_RST;
      else if (i_preset_value_write_op.wr)
         preset_q <= i_preset_value_write_op.data;
   end

   // ==========================================================================
   // Current count
   // ==========================================================================

   assign move_up = i_count_enable_cmd & i_step_up & ~i_step_dn;
   assign move_dn = i_count_enable_cmd & i_step_dn & ~i_step_up;

   // preset load
   // A preset wins over a step in the same cycle and ignores the enable.
   // Range limits are handled outside; the count simply wraps here.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         count_q <= COUNT_RST;
      else if (preset_fire)
         count_q <= preset_q;
      else if (move_up)
         count_q <= count_q + COUNT_STEP;
      else if (move_dn)
         count_q <= count_q - COUNT_STEP;
   end

   // ==========================================================================
   // Compare points
   // ==========================================================================

   assign point_wr[POINT_ONE] = i_compare_point_write_op_one;
   assign point_wr[POINT_TWO] = i_compare_point_write_op_two;
   assign mrst                = {i_match_reset_cmd_two, i_match_reset_cmd_one};

   always_ff @(posedge i_ref_clk)
   begin
      for (int i = 0; i < NUM_POINTS; i++)
      begin
         if (!i_rst_n)
            point_q[i] <= COMPARE_RST;
         else if (point_wr[i].wr)
            point_q[i] <= point_wr[i].data;
      end
   end

   for (genvar gi = 0; gi < NUM_POINTS; gi++)
   begin : g_point
      cnt_compare i_cnt_compare
      (
         .i_count (count_q),
         .i_point (point_q[gi]),
         .o_res   (res[gi])
      );

      // latch
      // The reset command wins; releasing it during equality sets again
      assign flag_d[gi] = ~mrst[gi] & (flag_q[gi] | res[gi].eq);
   end

   // ==========================================================================
   // Match flags and pins
   // ==========================================================================

   // flag and pin
   // The pin is registered from the same next value as the flag, so the
   // two never drift apart by a cycle.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         flag_q <= '0;
         out_q  <= '0;
      end
      else
      begin
         flag_q <= flag_d;
         out_q  <= flag_d & {NUM_POINTS{i_match_output_enable_cmd}};
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         res_one_q <= '0;
      else
         res_one_q <= res[POINT_ONE];
   end

   // ==========================================================================
   // Outputs, all taken from registers
   // ==========================================================================

   assign o_current_count           = count_q;
   assign o_ext_preset_request_flag = req_q;
   assign o_res_one                 = res_one_q;
   assign o_match_flag_one          = flag_q[POINT_ONE];
   assign o_match_flag_two          = flag_q[POINT_TWO];
   assign o_match_out_one           = out_q[POINT_ONE];
   assign o_match_out_two           = out_q[POINT_TWO];

   // ==========================================================================
   // Assertions
   // ==========================================================================

   default clocking cb_main @(posedge i_ref_clk);
   endclocking

   default disable iff (!i_rst_n);

   AST_PRESET_LOAD: assert property (
      preset_fire |=> (count_q == $past(preset_q)))
      else $error("Preset did not load the held value");

   AST_PRESET_BLOCKED: assert property (
      (req_q && !move_up && !move_dn) |=> (count_q == $past(count_q)))
      else $error("Count changed while presets were blocked");

   AST_REQ_SET: assert property (
      req_set |=> req_q)
      else $error("Index preset did not set the request flag");

   AST_REQ_LEVEL: assert property (
      (!req_q && i_preset_cfg.trig_sel == TRIG_LEVEL)
      |=> !req_q)
      else $error("Level trigger set the request flag");

   AST_REQ_CLEAR: assert property (
      (req_q && i_ext_preset_request_clear_cmd) |=> !req_q)
      else $error("Request flag did not clear");

   AST_MATCH_SET: assert property (
      (res[POINT_ONE].eq && !i_match_reset_cmd_one) |=> o_match_flag_one)
      else $error("Equality did not set match flag one");

   AST_MATCH_HOLD: assert property (
      i_match_reset_cmd_one |=> (!o_match_flag_one && !o_match_out_one))
      else $error("Match reset did not hold flag one off");

   AST_OUT_GATE: assert property (
      !i_match_output_enable_cmd |=> (!o_match_out_one && !o_match_out_two))
      else $error("Match pin driven while disabled");

   AST_LT_FLAG: assert property (
      o_res_one.lt == ($past(count_q) < $past(point_q[POINT_ONE])))
      else $error("Less-than flag wrong");

   AST_GT_FLAG: assert property (
      o_res_one.gt == ($past(count_q) > $past(point_q[POINT_ONE])))
      else $error("Greater-than flag wrong");

   // Main scenarios worth seeing at least once
   COV_INDEX_PRESET: cover property (req_set);

   COV_MATCH_PIN: cover property ($rose(o_match_out_one));

   COV_BLOCKED_PRESET: cover property (req_q && prog_rise);

endmodule // cnt_match_point

// >>> testbench/pulse_src.sv
// Far-side model: decoded encoder steps and the index pin
module pulse_src
(
   input  wire logic i_ref_clk,
   input  wire logic i_run,
   input  wire logic i_up,
   input  wire logic i_index_lvl,
   output logic      o_step_up,
   output logic      o_step_dn,
   output logic      o_index
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      o_step_up = 1'b0;
      o_step_dn = 1'b0;
      o_index   = 1'b0;
   end
   // One step a clock while running; changes land just after the edge
   always @(posedge i_ref_clk)
   begin
      o_step_up <= #1 i_run & i_up;
      o_step_dn <= #1 i_run & ~i_up;
      o_index   <= #1 i_index_lvl;
   end
endmodule // pulse_src

// >>> testbench/cnt_match_point_tb_top.sv
// Bench: counter channel driven by a step and index source
module cnt_match_point_tb_top;
   import cnt_preset_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WD_CYCLES = 1000;
   logic        i_ref_clk = 1'b0;
   logic        i_rst_n   = 1'b0;
   logic        run = 1'b0, up = 1'b0, idx = 1'b0;
   logic        cnt_en = 1'b0, prog = 1'b0, oe = 1'b0, clr = 1'b0;
   logic        mrst1 = 1'b0, mrst2 = 1'b0;
   logic        st_up, st_dn, idx_pin;
   preset_cfg_t cfg = '0;
   wr_port_t    pre_wr = '0, pt1_wr = '0, pt2_wr = '0;
   count_t      cnt;
   cmp_res_t    res;
   logic        req, flag1, flag2, out1, out2;
   int          err_count = 0;
   int          compares = 0;
   always #2 i_ref_clk = ~i_ref_clk;
   pulse_src i_pulse_src (.i_ref_clk(i_ref_clk), .i_run(run), .i_up(up),
      .i_index_lvl(idx), .o_step_up(st_up), .o_step_dn(st_dn),
      .o_index(idx_pin));
   cnt_match_point i_cnt_match_point (.i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n), .i_preset_cfg(cfg), .i_index(idx_pin),
      .i_step_up(st_up), .i_step_dn(st_dn), .i_count_enable_cmd(cnt_en),
      .i_program_preset_cmd(prog), .i_preset_value_write_op(pre_wr),
      .i_compare_point_write_op_one(pt1_wr),
      .i_compare_point_write_op_two(pt2_wr),
      .i_match_reset_cmd_one(mrst1), .i_match_reset_cmd_two(mrst2),
      .i_match_output_enable_cmd(oe),
      .i_ext_preset_request_clear_cmd(clr), .o_current_count(cnt),
      .o_ext_preset_request_flag(req), .o_res_one(res),
      .o_match_flag_one(flag1), .o_match_flag_two(flag2),
      .o_match_out_one(out1), .o_match_out_two(out2));
   task automatic step(int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic write_preset(count_t v);
      pre_wr = {1'b1, v};
      step(1);
      pre_wr = '0;
      step(1);
   endtask
   task automatic write_point(int n, count_t v);
      if (n == 0)
         pt1_wr = {1'b1, v};
      else
         pt2_wr = {1'b1, v};
      step(1);
      pt1_wr = '0;
      pt2_wr = '0;
      step(1);
   endtask
   task automatic pulse_prog;
      prog = 1'b1;
      step(1);
      prog = 1'b0;
      step(3);
   endtask
   task automatic chk_count(string nm, count_t e);
      compares++;
      if (cnt !== e)
      begin
         err_count++;
         $display("ERROR %s exp %0d got %0d", nm, e, cnt);
      end
   endtask
   task automatic chk_cmp(string nm, logic [3:0] e);
      compares++;
      if ({res, flag1} !== e)
      begin
         err_count++;
         $display("ERROR %s exp %h got %h", nm, e, {res, flag1});
      end
   endtask
   task automatic chk_bit(string nm, logic e, logic g);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic give_verdict;
      if (err_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      step(3);
      i_rst_n = 1'b1;
      step(2);
      write_point(0, 32'sh0000_0005);
      write_point(1, 32'shFFFF_FFFF);
      write_preset(32'sh0000_000A);
      mrst1 = 1'b1;
      mrst2 = 1'b1;
      step(2);
      mrst1 = 1'b0;
      mrst2 = 1'b0;
      step(2);
      chk_count("preset_write_keeps_count", 32'sh0000_0000);
      chk_cmp("below_point", 4'h8);
      pulse_prog();
      chk_count("program_preset", 32'sh0000_000A);
      chk_cmp("above_point", 4'h2);
      cnt_en = 1'b1;
      run = 1'b1;
      step(5);
      run = 1'b0;
      step(3);
      chk_count("count_down", 32'sh0000_0005);
      chk_cmp("equal_point", 4'h5);
      chk_bit("pin_gated", 1'b0, out1);
      oe = 1'b1;
      mrst1 = 1'b1;
      step(3);
      chk_cmp("reset_held", 4'h4);
      chk_bit("pin_reset", 1'b0, out1);
      mrst1 = 1'b0;
      step(3);
      chk_cmp("reset_released", 4'h5);
      chk_bit("pin_on", 1'b1, out1);
      run = 1'b1;
      step(6);
      run = 1'b0;
      step(3);
      chk_count("below_zero", 32'shFFFF_FFFF);
      chk_cmp("latched_below", 4'h9);
      chk_bit("point_two_flag", 1'b1, flag2);
      chk_bit("pin_two", 1'b1, out2);
      cfg = {TRIG_RISE, 1'b1};
      write_preset(32'shFFFF_FFF9);
      step(4);
      idx = 1'b1;
      step(5);
      chk_count("index_rise", 32'shFFFF_FFF9);
      chk_bit("req_set", 1'b1, req);
      write_preset(32'sh0000_0014);
      pulse_prog();
      chk_count("blocked", 32'shFFFF_FFF9);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      step(2);
      chk_bit("req_clear", 1'b0, req);
      pulse_prog();
      chk_count("rearmed", 32'sh0000_0014);
      idx = 1'b0;
      step(5);
      chk_count("fall_ignored", 32'sh0000_0014);
      cfg = {TRIG_FALL, 1'b0};
      write_preset(32'sh0000_0003);
      step(4);
      idx = 1'b1;
      step(5);
      chk_count("no_rise_in_fall", 32'sh0000_0014);
      idx = 1'b0;
      step(5);
      chk_count("index_fall", 32'sh0000_0003);
      chk_bit("req_off", 1'b0, req);
      cfg = {TRIG_LEVEL, 1'b1};
      write_preset(32'shFFFF_FFFE);
      step(4);
      idx = 1'b1;
      run = 1'b1;
      step(6);
      chk_count("level_hold", 32'shFFFF_FFFE);
      chk_bit("req_level", 1'b0, req);
      run = 1'b0;
      idx = 1'b0;
      step(5);
      cfg = {TRIG_BOTH, 1'b0};
      write_preset(32'sh0000_0008);
      step(4);
      idx = 1'b1;
      step(5);
      chk_count("both_rise", 32'sh0000_0008);
      up = 1'b1;
      run = 1'b1;
      step(2);
      run = 1'b0;
      step(3);
      chk_count("count_up", 32'sh0000_000A);
      idx = 1'b0;
      step(5);
      chk_count("both_fall", 32'sh0000_0008);
      give_verdict();
   end
   initial
   begin
      repeat (WD_CYCLES) @(posedge i_ref_clk);
      err_count++;
      give_verdict();
   end
endmodule // cnt_match_point_tb_top
